// *** common/nv_port_pkg.sv ***
// Constants and carrier types for the muxed nonvolatile memory port.
package nv_port_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  localparam int DEPTH = 2048;
  localparam int CMD_BIT = 7;
  localparam int HI_ADDR_MSB = 2;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DDR_RESET = 8'h00;

  typedef enum logic [1:0] {
    PH_HIGH,
    PH_LOW,
    PH_DATA
  } phase_t;

  typedef struct packed {
    logic [7:0] port_in;
    logic [7:0] bus_in;
    logic mem_sel_n;
    logic xfer_clk;
  } pins_in_t;
endpackage : nv_port_pkg

// *** verilog/nv_mem.sv ***
// Single-port 2048 x 8 storage array with a registered read port.
module nv_mem (
  // Clock
  input wire logic clk,
  // Access
  input wire logic we,
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:nv_port_pkg::DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : nv_mem

// *** verilog/muxed_nv_sram_port.sv ***
// Muxed address/data nonvolatile memory port with pass-through outputs.

module muxed_nv_sram_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host side
  input wire logic [7:0] port_in,
  input wire logic [7:0] bus_in,
  input wire logic mem_sel_n,
  input wire logic xfer_clk,
  output logic [7:0] bus_out,
  output logic bus_oe_n,
  // External port
  output logic [7:0] port_out,
  output logic [7:0] port_oe_n,
  // Power monitor
  input wire logic supply_low_5,
  input wire logic supply_low_10,
  input wire logic fail_threshold_sel,
  output logic power_fail_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  nv_port_pkg::pins_in_t meta;
  nv_port_pkg::pins_in_t pins;
  logic [1:0] fail_meta;
  logic [1:0] fail_sync;
  logic sel_meta;
  logic sel_sync;
  logic clk_d;

  // Every pin is an asynchronous level, so each one passes two flip-flops
  // before any logic reads it. The threshold strap is treated the same way,
  // since a strap that moves while the supply is marginal must not glitch
  // the power-fail output.
  always_ff @(posedge clk) begin
    meta <= {port_in, bus_in, mem_sel_n, xfer_clk};
    pins <= meta;
    fail_meta <= {supply_low_10, supply_low_5};
    fail_sync <= fail_meta;
    sel_meta <= fail_threshold_sel;
    sel_sync <= sel_meta;
  end

  // Each transfer is taken on the falling edge of the transfer clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= pins.xfer_clk;
    end
  end

  // The edge detector resets to the idle low level of the transfer clock,
  // so no false strobe follows the release of reset.
  logic strobe;
  assign strobe = clk_d & ~pins.xfer_clk;

  // High on the strobe that takes a transfer while the sequencer is in the
  // given phase.
  function automatic logic take_in(
    input nv_port_pkg::phase_t cur,
    input nv_port_pkg::phase_t want,
    input logic stb
  );
    take_in = stb && (cur == want);
  endfunction : take_in

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  nv_port_pkg::phase_t phase;
  logic is_read;
  logic [2:0] addr_hi;
  logic [10:0] addr;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] ddr;
  logic in_xfer;

  // The phase counter wraps after the data transfer, so the next strobe is
  // always taken as the first address transfer of a new access.
  // Three-transfer sequence.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= nv_port_pkg::PH_HIGH;
    end else if (strobe) begin
      case (phase)
        nv_port_pkg::PH_HIGH: phase <= nv_port_pkg::PH_LOW;
        nv_port_pkg::PH_LOW: phase <= nv_port_pkg::PH_DATA;
        default: phase <= nv_port_pkg::PH_HIGH;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      is_read <= 1'b0;
      addr_hi <= 3'h0;
      addr <= 11'h000;
    end else if (take_in(phase, nv_port_pkg::PH_HIGH, strobe)) begin
      is_read <= pins.bus_in[nv_port_pkg::CMD_BIT];
      addr_hi <= pins.bus_in[nv_port_pkg::HI_ADDR_MSB:0];
    end else if (take_in(phase, nv_port_pkg::PH_LOW, strobe)) begin
      addr <= {addr_hi, pins.bus_in};
    end
  end

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  // The array is not cleared by reset; its contents are undefined until written.
  // Direction from command.
  assign mem_we = take_in(phase, nv_port_pkg::PH_DATA, strobe) && !is_read && !pins.mem_sel_n;

  nv_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(addr),
    .wdata(pins.bus_in),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // Direction register
  // ----------------------------------------
  // A set bit floats the matching port output during transfers.
  // Select high steers data transfer to the direction register.
  always_ff @(posedge clk) begin
    if (rst) begin
      ddr <= nv_port_pkg::DDR_RESET;
    end else if (take_in(phase, nv_port_pkg::PH_DATA, strobe) && !is_read && pins.mem_sel_n) begin
      ddr <= pins.bus_in;
    end
  end

  // ----------------------------------------
  // Shared bus drive
  // ----------------------------------------
  // The enable follows the synchronised clock level, so the bus is released
  // a few cycles after the host lowers the clock; the host must not drive
  // the lines again until then.
  // Drive bus only in read data phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_out <= 8'h00;
      bus_oe_n <= 1'b1;
    end else begin
      bus_out <= pins.mem_sel_n ? ddr : mem_rdata;
      bus_oe_n <= !(phase == nv_port_pkg::PH_DATA && is_read && pins.xfer_clk);
    end
  end

  // ----------------------------------------
  // Port outputs
  // ----------------------------------------
  // A transfer is in progress for the whole time select is low.
  // With select high the clock frames the access.
  assign in_xfer = !pins.mem_sel_n || phase != nv_port_pkg::PH_HIGH || pins.xfer_clk;

  always_ff @(posedge clk) begin
    if (rst) begin
      port_out <= nv_port_pkg::PORT_RESET;
      port_oe_n <= 8'h00;
    end else if (!in_xfer) begin
      port_out <= pins.port_in;
      port_oe_n <= 8'h00;
    end else begin
      port_oe_n <= ddr;
    end
  end

  // ----------------------------------------
  // Power monitor
  // ----------------------------------------
  // The output is a level, not a sticky flag: it clears once the selected
  // comparator reports a good supply again.
  // Power-fail detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      power_fail_out <= 1'b0;
    end else begin
      power_fail_out <= sel_sync ? fail_sync[1] : fail_sync[0];
    end
  end
endmodule : muxed_nv_sram_port

// *** dv/nv_port_checker.sv ***
// Pin-level checks for the memory port.
module nv_port_checker (
  input wire logic clk, rst, mem_sel_n, xfer_clk, bus_oe_n, power_fail_out,
  input wire logic supply_low_5, supply_low_10, fail_threshold_sel,
  input wire logic [7:0] port_in, port_out, port_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic lvl = fail_threshold_sel ? supply_low_10 : supply_low_5;
  reset_vals_a: assert property (disable iff (1'b0) rst |=> bus_oe_n && !power_fail_out)
    else $error("reset values");
  read_drive_a: assert property (!bus_oe_n |-> $past(xfer_clk, 2) || $past(xfer_clk, 4))
    else $error("bus drive");
  drive_hold_a: assert property ($fell(bus_oe_n) |=> !bus_oe_n[*2])
    else $error("drive short");
  pass_thru_a: assert property ((mem_sel_n && !xfer_clk && $stable(port_in))[*8]
    |-> port_out == port_in && port_oe_n == 8'h00) else $error("pass through");
  sel_freeze_a: assert property (!mem_sel_n[*5] |=> $stable(port_out))
    else $error("freeze");
  xfer_hold_a: assert property (xfer_clk[*6] |=> $stable(port_out))
    else $error("hold");
  pf_set_a: assert property (lvl[*5] |-> power_fail_out)
    else $error("pf set");
  pf_clear_a: assert property (!lvl[*5] |-> !power_fail_out)
    else $error("pf clear");
  cover property ($fell(bus_oe_n));
  cover property ($rose(power_fail_out));
  cover property ($fell(mem_sel_n));
endmodule : nv_port_checker

bind muxed_nv_sram_port nv_port_checker chk (.clk, .rst, .mem_sel_n, .xfer_clk, .bus_oe_n,
  .power_fail_out, .supply_low_5, .supply_low_10, .fail_threshold_sel, .port_in, .port_out,
  .port_oe_n);

// *** dv/nv_host_model.sv ***
// Host model that sequences select, clock and the shared lines.
module nv_host_model (
  input wire logic clk,
  input wire logic bus_oe_n,
  input wire logic [7:0] bus_out,
  output logic [7:0] bus_in = 8'h00,
  output logic mem_sel_n = 1'b1,
  output logic xfer_clk = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one transfer; a released bus reads as all X.
  task automatic cyc(input logic [7:0] b, input logic rd, output logic [7:0] q);
    bus_in = rd ? ~bus_in : b;
    xfer_clk = 1'b1;
    repeat (6) @(negedge clk);
    q = bus_oe_n ? 8'hxx : bus_out;
    xfer_clk = 1'b0;
    repeat (5) @(negedge clk);
  endtask : cyc
  // select, then command byte, low address, data.
  task automatic access(input logic sel_n, input logic rd, input logic [10:0] a,
      input logic [7:0] d, output logic [7:0] q);
    mem_sel_n = sel_n;
    repeat (5) @(negedge clk);
    cyc({rd, 4'h0, a[10:8]}, 1'b0, q);
    cyc(a[7:0], 1'b0, q);
    cyc(d, rd, q);
  endtask : access
endmodule : nv_host_model

// *** dv/testbench.sv ***
// Self-checking bench for the memory port.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supply_low_5 = 1'b0, supply_low_10 = 1'b0, fail_threshold_sel = 1'b0;
  logic [7:0] port_in = 8'h00, bus_in, bus_out, port_out, port_oe_n, q;
  logic mem_sel_n, xfer_clk, bus_oe_n, power_fail_out;
  int bad_count = 0, num_checks = 0, cycles = 0;
  muxed_nv_sram_port uut (.clk, .rst, .port_in, .bus_in, .mem_sel_n, .xfer_clk, .bus_out,
    .bus_oe_n, .port_out, .port_oe_n, .supply_low_5, .supply_low_10, .fail_threshold_sel,
    .power_fail_out);
  nv_host_model host (.clk, .bus_oe_n, .bus_out, .bus_in, .mem_sel_n, .xfer_clk);
  always #10 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic t_port;
    port_in = 8'h3c;
    repeat (8) @(negedge clk);
    chk("pass", 8'h3c, port_out);
    host.access(1'b1, 1'b0, 11'h000, 8'hf0, q);
    host.access(1'b1, 1'b1, 11'h000, 8'h00, q);
    chk("ddr", 8'hf0, q);
    host.access(1'b0, 1'b1, 11'h000, 8'h00, q);
    port_in = 8'hc3;
    repeat (8) @(negedge clk);
    chk("frozen", 8'h3c, port_out);
    chk("oe", 8'hf0, port_oe_n);
    $display("port done");
  endtask : t_port
  task automatic t_mem;
    host.access(1'b0, 1'b0, 11'h7ff, 8'h5a, q);
    host.access(1'b0, 1'b0, 11'h0ff, 8'ha3, q);
    host.access(1'b0, 1'b1, 11'h7ff, 8'h00, q);
    chk("rd 7ff", 8'h5a, q);
    host.access(1'b0, 1'b1, 11'h0ff, 8'h00, q);
    chk("rd 0ff", 8'ha3, q);
    $display("mem done");
  endtask : t_mem
  task automatic t_pf;
    logic [3:0] v [4] = '{4'h3, 4'h4, 4'hd, 4'ha};
    for (int i = 0; i < 4; i++) begin
      {fail_threshold_sel, supply_low_10, supply_low_5} = v[i][3:1];
      repeat (6) @(negedge clk);
      chk("pf", {7'h00, v[i][0]}, {7'h00, power_fail_out});
    end
    $display("pf done");
  endtask : t_pf
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_port();
    t_mem();
    t_pf();
    test_done();
  end
endmodule : testbench
